// ===== logic/scu_pkg.sv
// Shared constants and carrier types for the card UART status/FIFO block.
// Assumes an 8-bit host bus with a 4-bit address and ETU ticks from outside.
package scu_pkg;

   // Register addresses on the host bus
   localparam logic [3:0] ADR_TIMEOUT_CFG = 4'h8;
   localparam logic [3:0] ADR_TIMEOUT_HIGH = 4'hB;
   localparam logic [3:0] ADR_MIXED = 4'hC;
   localparam logic [3:0] ADR_DATA_PORT = 4'hD;

   // Mixed status bit positions
   localparam int MS_CLK_SRC = 7;
   localparam int MS_FIFO_EMPTY = 6;
   localparam int MS_GUARD = 5;
   localparam int MS_READY = 4;
   localparam int MS_CARD_B = 3;
   localparam int MS_CARD_A = 2;
   localparam int MS_AUX = 1;
   localparam int MS_BUF_RDY = 0;

   // FIFO control fields and reset values
   localparam int FC_LIMIT_LSB = 4;
   localparam int FC_THR_HI = 3;
   localparam int FC_DEPTH_LSB = 0;
   localparam logic [7:0] FC_RESET = 8'h00;
   localparam logic [7:0] FC_UART_RST_MASK = 8'h77;
   localparam logic [7:0] TIMEOUT_HIGH_RESET = 8'h00;
   localparam int FIFO_SLOTS = 8;

   // Timing counts
   localparam logic [1:0] READY_HOLD_CYCLES = 2'h3;
   localparam logic [4:0] GUARD_ETU_T0 = 5'h10;
   localparam logic [4:0] GUARD_ETU_T1 = 5'h16;
   localparam int RETX_ETU = 15;
   localparam int MANUAL_ETU_X10 = 135;
   localparam logic [4:0] RETX_HALVES = 5'(2 * RETX_ETU);
   localparam logic [4:0] MANUAL_HALVES = 5'(2 * MANUAL_ETU_X10 / 10);

   typedef struct packed {
      logic csN;
      logic rdN;
      logic wrN;
      logic [3:0] addr;
      logic [7:0] data;
   } scu_host_bus_t;

   typedef struct packed {
      logic etuTick;
      logic halfEtuTick;
      logic prescTick;
      logic startBit;
      logic txDone;
      logic txNak;
      logic rxDone;
      logic rxParityBad;
   } scu_uart_evt_t;

endpackage

// ===== logic/scu_ready_timer.sv
// Host-access ready timing after data port and timeout config accesses.
// Assumes one-cycle request pulses and a prescaler tick from outside.
`timescale 1ns/1ps
module scu_ready_timer
   import scu_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Requests
   input wire logic syncMode,
   input wire logic shortReq,
   input wire logic longReq,
   input wire logic prescTick,
   // Status
   output logic ready
);

   typedef enum logic [1:0] {
      RT_IDLE = 2'b00,
      RT_SHORT = 2'b01,
      RT_PSC1 = 2'b11,
      RT_PSC2 = 2'b10
   } scu_rt_state_t;

   scu_rt_state_t state_q;
   logic [1:0] holdCnt_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= RT_IDLE;
         holdCnt_q <= 2'h0;
      end else begin
         unique case (state_q)
            RT_IDLE: begin
               if (longReq && !syncMode) begin
                  state_q <= RT_PSC1;
               end else if (shortReq && !syncMode) begin
                  state_q <= RT_SHORT;
                  holdCnt_q <= READY_HOLD_CYCLES - 2'h1;
               end
            end
            RT_SHORT: begin
               if (holdCnt_q == 2'h0) begin
                  state_q <= RT_IDLE;
               end else begin
                  holdCnt_q <= holdCnt_q - 2'h1;
               end
            end
            // First tick lands anywhere within one period, so 1 to 2 total
            RT_PSC1: begin
               if (prescTick) begin
                  state_q <= RT_PSC2;
               end
            end
            RT_PSC2: begin
               if (prescTick) begin
                  state_q <= RT_IDLE;
               end
            end
         endcase
      end
   end

   assign ready = syncMode || (state_q == RT_IDLE);

   AST_SHORT_HOLD: assert property (
      @(posedge core_clk) disable iff (reset)
      (state_q == RT_IDLE && shortReq && !longReq && !syncMode)
      |=> !ready [*3] ##1 ready)
      else $error("ready not low for exactly three cycles");

   AST_SYNC_READY: assert property (
      @(posedge core_clk) disable iff (reset)
      syncMode |-> ready)
      else $error("ready low in synchronous mode");

   AST_LONG_HOLD: assert property (
      @(posedge core_clk) disable iff (reset)
      (state_q == RT_IDLE && longReq && !syncMode)
      |=> !ready ##1 (syncMode || !ready))
      else $error("ready not held after timeout config write");

endmodule

// ===== logic/scu_parity_ctl.sv
// Parity error counting, automatic retransmission and resend hold-off.
// Assumes half-ETU ticks and one-cycle character events from the UART core.
`timescale 1ns/1ps
module scu_parity_ctl
   import scu_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Context
   input wire logic uartRun,
   input wire logic protocolT1,
   input wire logic txMode,
   input wire logic [2:0] parityRetryLimit,
   input wire scu_uart_evt_t uartEvt,
   // Results
   output logic parityErrSet,
   output logic retransmitStart,
   output logic resendHold
);

   logic [3:0] errCnt_q;
   logic [4:0] halfCnt_q;
   logic retxPend_q;
   logic failHold_q;
   logic atLimit;
   logic halfWrap;

   // A limit lowered below the running count still ends the retries
   assign atLimit = errCnt_q >= {1'b0, parityRetryLimit};
   assign halfWrap = uartEvt.halfEtuTick && halfCnt_q != 5'h1f;

   // Half-ETU timer measured from the latest start bit
   always_ff @(posedge core_clk) begin
      if (reset || uartEvt.startBit) begin
         halfCnt_q <= 5'h00;
      end else if (halfWrap) begin
         halfCnt_q <= halfCnt_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !uartRun) begin
         errCnt_q <= 4'h0;
         retxPend_q <= 1'b0;
         failHold_q <= 1'b0;
         parityErrSet <= 1'b0;
         retransmitStart <= 1'b0;
      end else begin
         parityErrSet <= 1'b0;
         retransmitStart <= 1'b0;
         if (retxPend_q && halfWrap && halfCnt_q == RETX_HALVES - 5'h01) begin
            retxPend_q <= 1'b0;
            retransmitStart <= 1'b1;
         end
         if (failHold_q && halfCnt_q >= MANUAL_HALVES) begin
            failHold_q <= 1'b0;
         end
         if (txMode && !protocolT1 && uartEvt.txNak) begin
            if (!atLimit) begin
               errCnt_q <= errCnt_q + 4'h1;
               retxPend_q <= 1'b1;
            end else begin
               errCnt_q <= 4'h0;
               parityErrSet <= 1'b1;
               failHold_q <= 1'b1;
            end
         end else if (txMode && uartEvt.txDone) begin
            errCnt_q <= 4'h0;
         end else if (!txMode && uartEvt.rxDone) begin
            if (protocolT1) begin
               parityErrSet <= uartEvt.rxParityBad;
            end else if (!uartEvt.rxParityBad) begin
               errCnt_q <= 4'h0;
            end else if (atLimit) begin
               errCnt_q <= 4'h0;
               parityErrSet <= 1'b1;
            end else begin
               errCnt_q <= errCnt_q + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         resendHold <= 1'b0;
      end else begin
         resendHold <= failHold_q && halfCnt_q < MANUAL_HALVES;
      end
   end

   AST_RETX_AT_15: assert property (
      @(posedge core_clk) disable iff (reset)
      retransmitStart |-> $past(halfCnt_q) == RETX_HALVES - 5'h01)
      else $error("retransmission not at fifteen ETU");

   AST_NO_AUTO_RETX: assert property (
      @(posedge core_clk) disable iff (reset)
      (uartRun && txMode && !protocolT1 && uartEvt.txNak
       && parityRetryLimit == 3'h0) |=> !retxPend_q && parityErrSet)
      else $error("retry scheduled with zero limit");

   AST_T1_EVERY_ERR: assert property (
      @(posedge core_clk) disable iff (reset)
      (uartRun && !txMode && protocolT1 && uartEvt.rxDone
       && uartEvt.rxParityBad) |=> parityErrSet)
      else $error("T1 parity error not flagged");

   AST_RX_LIMIT: assert property (
      @(posedge core_clk) disable iff (reset)
      (uartRun && !txMode && !protocolT1 && uartEvt.rxDone
       && uartEvt.rxParityBad && !atLimit) |=> !parityErrSet)
      else $error("parity error flagged before limit");

endmodule

// ===== logic/scu_status_fifo.sv
// Status, FIFO control and receive FIFO of the card UART, host bus side.
// Assumes host strobes synchronous to core_clk and UART core event pulses.
//
// Summary of operation
// - Timeout high byte is write-only, kept through UART reset.
// - Clock source bit reads 1 on internal oscillator, 0 on crystal.
// - FIFO empty bit is 1 when no received character is stored.
// - Guard counter restarts per start bit, sets bit at 16 or 22 ETU.
// - Ready stays low three cycles after a data port read.
// - Ready stays low three cycles after a data port write.
// - Ready stays low one to two prescaler periods after timeout config write, not during UART reset.
// - Ready delays only in asynchronous mode; forced high when synchronous.
// - Card A and B presence bits follow detection.
// - Aux interrupt bit follows the aux pin level.
// - Buffer flag set on receive-to-transmit, character sent, FIFO full.
// - Buffer flag cleared on reset, transmit write, FIFO read, back to receive.
// - Buffer flag not set after the marked last character.
// - T0 transmit retries up to the limit, then parity error.
// - Each retry starts 15 ETU after previous start bit.
// - Zero limit means no retry; manual resend not before 13.5 ETU.
// - T0 receive flags parity error after limit plus one errors.
// - A good character resets the parity error counter.
// - T1 flags every received parity error, no counter.
// - Threshold enabled only when both enable bits set; bits read 0.
// - FIFO depth is the length field plus one.
// - Marked last character done ends transmit and clears the buffer flag.
`timescale 1ns/1ps
module scu_status_fifo
   import scu_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Host bus
   input wire scu_host_bus_t hostBus,
   output logic [7:0] dataOut,
   output logic dataOutEnN,
   // UART context
   input wire logic uartResetRelease,
   input wire logic protocolT1,
   input wire logic txMode,
   input wire logic lastCharMarker,
   input wire logic syncMode,
   input wire logic thresholdEnableLo,
   // Card and pin status
   input wire logic cardClockInternal,
   input wire logic cardAPresent,
   input wire logic cardBPresent,
   input wire logic auxIrqPin,
   // UART core events
   input wire scu_uart_evt_t uartEvt,
   input wire logic [7:0] rxData,
   // Towards the UART core
   output logic [7:0] timeoutCountHigh,
   output logic [2:0] parityRetryLimit,
   output logic thresholdActive,
   output logic bufferReadyFlag,
   output logic parityErrSet,
   output logic retransmitStart,
   output logic resendHold,
   output logic lastCharDone,
   output logic rxFifoEmptyFlag,
   output logic blockGuardElapsed,
   output logic hostAccessReady
);

   scu_host_bus_t prevBus_q;
   logic [7:0] fifoControl_q;
   logic [7:0] fifoMem [FIFO_SLOTS];
   logic [2:0] wrPtr_q;
   logic [2:0] rdPtr_q;
   logic [3:0] fifoCount_q;
   logic [3:0] fifoDepth;
   logic fifoFull;
   logic fullPrev_q;
   logic txModePrev_q;
   logic lctLoaded_q;
   logic [4:0] guardCnt_q;
   logic [4:0] guardTerm;
   logic readNow;
   logic writeNow;
   logic readEnd;
   logic writeEnd;
   logic dataWrite;
   logic dataRead;
   logic cfgWrite;
   logic fifoPush;
   logic fifoPop;
   logic timerReady;
   logic setBuf;
   logic clrBuf;
   logic [7:0] mixedStatus;

   // Strobe end detection: actions take effect at the rising edge
   assign readNow = !hostBus.csN && !hostBus.rdN;
   assign writeNow = !hostBus.csN && !hostBus.wrN;
   assign readEnd = !prevBus_q.csN && !prevBus_q.rdN && !readNow;
   assign writeEnd = !prevBus_q.csN && !prevBus_q.wrN && !writeNow;
   assign dataWrite = writeEnd && prevBus_q.addr == ADR_DATA_PORT;
   assign dataRead = readEnd && prevBus_q.addr == ADR_DATA_PORT;
   assign cfgWrite = writeEnd && prevBus_q.addr == ADR_TIMEOUT_CFG
                     && uartResetRelease;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         prevBus_q <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
      end else begin
         prevBus_q <= hostBus;
      end
   end

   // Timeout high byte survives the UART reset, only the core reset clears it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         timeoutCountHigh <= TIMEOUT_HIGH_RESET;
      end else if (writeEnd && prevBus_q.addr == ADR_TIMEOUT_HIGH) begin
         timeoutCountHigh <= prevBus_q.data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         fifoControl_q <= FC_RESET;
      end else if (writeEnd && prevBus_q.addr == ADR_MIXED) begin
         fifoControl_q <= prevBus_q.data;
      end else if (!uartResetRelease) begin
         fifoControl_q <= fifoControl_q & FC_UART_RST_MASK;
      end
   end

   assign parityRetryLimit = fifoControl_q[FC_LIMIT_LSB +: 3];

   always_ff @(posedge core_clk) begin
      if (reset) begin
         thresholdActive <= 1'b0;
      end else begin
         thresholdActive <= fifoControl_q[FC_THR_HI]
                            && thresholdEnableLo;
      end
   end

   // Receive FIFO; the depth can shrink below the fill, which reads as full
   assign fifoDepth = {1'b0, fifoControl_q[FC_DEPTH_LSB +: 3]}
                      + 4'h1;
   assign fifoFull = fifoCount_q >= fifoDepth;
   assign fifoPush = uartEvt.rxDone && !txMode && !fifoFull
                     && (protocolT1 || !uartEvt.rxParityBad);
   assign fifoPop = dataRead && fifoCount_q != 4'h0;

   always_ff @(posedge core_clk) begin
      if (fifoPush) begin
         fifoMem[wrPtr_q] <= rxData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !uartResetRelease) begin
         wrPtr_q <= 3'h0;
         rdPtr_q <= 3'h0;
         fifoCount_q <= 4'h0;
      end else begin
         if (fifoPush) begin
            wrPtr_q <= wrPtr_q + 3'h1;
         end
         if (fifoPop) begin
            rdPtr_q <= rdPtr_q + 3'h1;
         end
         if (fifoPush && !fifoPop) begin
            fifoCount_q <= fifoCount_q + 4'h1;
         end else if (fifoPop && !fifoPush) begin
            fifoCount_q <= fifoCount_q - 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rxFifoEmptyFlag <= 1'b1;
      end else begin
         rxFifoEmptyFlag <= fifoCount_q == 4'h0;
      end
   end

   // Buffer ready flag: set wins over the ordinary clears
   assign setBuf = (txMode && !txModePrev_q)
                   || (uartEvt.txDone && !lctLoaded_q)
                   || (fifoFull && !fullPrev_q);
   assign clrBuf = (dataWrite && txMode) || (fifoPop && !txMode)
                   || (!txMode && txModePrev_q)
                   || (uartEvt.txDone && lctLoaded_q);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         txModePrev_q <= 1'b0;
         fullPrev_q <= 1'b0;
      end else begin
         txModePrev_q <= txMode;
         fullPrev_q <= fifoFull;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !uartResetRelease) begin
         bufferReadyFlag <= 1'b0;
      end else if (setBuf) begin
         bufferReadyFlag <= 1'b1;
      end else if (clrBuf) begin
         bufferReadyFlag <= 1'b0;
      end
   end

   // Marker is judged at load time, so a late marker waits for the next load
   always_ff @(posedge core_clk) begin
      if (reset || !uartResetRelease) begin
         lctLoaded_q <= 1'b0;
         lastCharDone <= 1'b0;
      end else begin
         lastCharDone <= uartEvt.txDone && lctLoaded_q;
         if (dataWrite && txMode) begin
            lctLoaded_q <= lastCharMarker;
         end else if (uartEvt.txDone) begin
            lctLoaded_q <= 1'b0;
         end
      end
   end

   // Block guard time
   assign guardTerm = protocolT1 ? GUARD_ETU_T1 : GUARD_ETU_T0;

   always_ff @(posedge core_clk) begin
      if (reset || uartEvt.startBit) begin
         guardCnt_q <= 5'h00;
         blockGuardElapsed <= 1'b0;
      end else if (uartEvt.etuTick && !blockGuardElapsed) begin
         guardCnt_q <= guardCnt_q + 5'h01;
         blockGuardElapsed <= guardCnt_q + 5'h01 >= guardTerm;
      end
   end

   scu_ready_timer readyTimer (
      .core_clk(core_clk),
      .reset(reset),
      .syncMode(syncMode),
      .shortReq(dataRead || dataWrite),
      .longReq(cfgWrite),
      .prescTick(uartEvt.prescTick),
      .ready(timerReady)
   );

   scu_parity_ctl parityCtl (
      .core_clk(core_clk),
      .reset(reset),
      .uartRun(uartResetRelease),
      .protocolT1(protocolT1),
      .txMode(txMode),
      .parityRetryLimit(parityRetryLimit),
      .uartEvt(uartEvt),
      .parityErrSet(parityErrSet),
      .retransmitStart(retransmitStart),
      .resendHold(resendHold)
   );

   always_ff @(posedge core_clk) begin
      if (reset) begin
         hostAccessReady <= 1'b1;
      end else begin
         hostAccessReady <= timerReady;
      end
   end

   always_comb begin
      mixedStatus = 8'h00;
      mixedStatus[MS_CLK_SRC] = cardClockInternal;
      mixedStatus[MS_FIFO_EMPTY] = rxFifoEmptyFlag;
      mixedStatus[MS_GUARD] = blockGuardElapsed;
      mixedStatus[MS_READY] = hostAccessReady;
      mixedStatus[MS_CARD_B] = cardBPresent;
      mixedStatus[MS_CARD_A] = cardAPresent;
      mixedStatus[MS_AUX] = auxIrqPin;
      mixedStatus[MS_BUF_RDY] = bufferReadyFlag;
   end

   // Only the two read addresses owned here drive the shared data bus
   always_ff @(posedge core_clk) begin
      if (reset) begin
         dataOut <= 8'h00;
         dataOutEnN <= 1'b1;
      end else if (readNow && hostBus.addr == ADR_MIXED) begin
         dataOut <= mixedStatus;
         dataOutEnN <= 1'b0;
      end else if (readNow && hostBus.addr == ADR_DATA_PORT) begin
         dataOut <= fifoMem[rdPtr_q];
         dataOutEnN <= 1'b0;
      end else begin
         dataOutEnN <= 1'b1;
      end
   end

   AST_HIGH_KEPT: assert property (
      @(posedge core_clk) disable iff (reset)
      !(writeEnd && prevBus_q.addr == ADR_TIMEOUT_HIGH)
      |=> $stable(timeoutCountHigh))
      else $error("timeout high byte changed without a write");

   AST_EMPTY: assert property (
      @(posedge core_clk) disable iff (reset)
      fifoPush ##1 !fifoPop |=> !rxFifoEmptyFlag)
      else $error("empty flag set with a stored character");

   AST_GUARD: assert property (
      @(posedge core_clk) disable iff (reset)
      uartEvt.startBit |=> !blockGuardElapsed && guardCnt_q == 5'h00)
      else $error("guard counter not restarted by start bit");

   AST_TX_ENTRY: assert property (
      @(posedge core_clk) disable iff (reset)
      (uartResetRelease && txMode && !txModePrev_q) |=> bufferReadyFlag)
      else $error("buffer flag not set on entering transmit");

   AST_UART_RST: assert property (
      @(posedge core_clk) disable iff (reset)
      !uartResetRelease |=> !bufferReadyFlag && fifoCount_q == 4'h0)
      else $error("UART reset did not clear flag and FIFO");

   AST_LAST_CHAR: assert property (
      @(posedge core_clk) disable iff (reset)
      (uartResetRelease && uartEvt.txDone && lctLoaded_q
       && !(txMode && !txModePrev_q) && !(fifoFull && !fullPrev_q))
      |=> !bufferReadyFlag && lastCharDone)
      else $error("buffer flag set after marked last character");

   AST_MIXED_READ: assert property (
      @(posedge core_clk) disable iff (reset)
      (readNow && hostBus.addr == ADR_MIXED)
      |=> !dataOutEnN && dataOut[MS_AUX] == $past(auxIrqPin))
      else $error("mixed status read returned wrong data");

endmodule

// ===== sim/scu_host_model.sv
// Host microcontroller model on the byte-wide register bus.
// Assumes the bench calls access one at a time from a single process.
`timescale 1ns/1ps
module scu_host_model
   import scu_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Bus
   output scu_host_bus_t hostBus,
   input wire logic [7:0] dataOut,
   input wire logic dataOutEnN,
   input wire logic hostAccessReady
);
   initial hostBus = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};

   task automatic access(input logic rd, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      // Busy shows a few cycles late, so let it appear first
      repeat (4) @(posedge core_clk);
      #1;
      while (hostAccessReady !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      hostBus = '{1'b0, !rd, rd, a, d};
      repeat (2) @(posedge core_clk);
      #1;
      // An undriven bus reads inverted, so a missing enable fails
      q = dataOutEnN ? ~dataOut : dataOut;
      // Released data lines must not look like a held value
      hostBus = '{1'b1, 1'b1, 1'b1, a, ~d};
   endtask
endmodule

// ===== sim/tb_scu_status_fifo.sv
// Self-checking bench for the card UART status and FIFO block.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
module tb_scu_status_fifo
   import scu_pkg::*;
;
   logic core_clk, reset, uartResetRelease, protocolT1, txMode;
   logic lastCharMarker, syncMode, thresholdEnableLo, cardClockInternal;
   logic cardAPresent, cardBPresent, auxIrqPin, dataOutEnN;
   logic thresholdActive, bufferReadyFlag, parityErrSet, hostAccessReady;
   logic rxFifoEmptyFlag, blockGuardElapsed, retransmitStart, resendHold;
   logic lastCharDone;
   logic [7:0] rxData, dataOut, timeoutCountHigh, q, d, c0, c1;
   logic [2:0] parityRetryLimit;
   scu_host_bus_t hostBus;
   scu_uart_evt_t uartEvt;
   int seed, errCount, nChecks, peCount, rtCount, lcCount, n, i;

   scu_status_fifo uut (.core_clk, .reset, .hostBus, .dataOut, .dataOutEnN,
      .uartResetRelease, .protocolT1, .txMode, .lastCharMarker, .syncMode,
      .thresholdEnableLo, .cardClockInternal, .cardAPresent, .cardBPresent,
      .auxIrqPin, .uartEvt, .rxData, .timeoutCountHigh, .parityRetryLimit,
      .thresholdActive, .bufferReadyFlag, .parityErrSet, .retransmitStart,
      .resendHold, .lastCharDone, .rxFifoEmptyFlag, .blockGuardElapsed,
      .hostAccessReady);
   scu_host_model host (.core_clk, .hostBus, .dataOut, .hostAccessReady,
      .dataOutEnN);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // One-cycle pulses are counted so no check can miss them
   always @(posedge core_clk) begin
      if (parityErrSet === 1'b1) peCount++;
      if (retransmitStart === 1'b1) rtCount++;
      if (lastCharDone === 1'b1) lcCount++;
   end

   task automatic endSim();
      $display("checks %0d errors %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [7:0] g, e);
      nChecks++;
      if (g !== e) begin
         errCount++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic ev(input scu_uart_evt_t e, input int k);
      uartEvt = e;
      tick(k);
      uartEvt = '0;
      // Idle edge, so back-to-back pulses never re-drive in one step
      tick(1);
   endtask

   task automatic rx(input logic bad);
      rxData = 8'($random(seed));
      ev('{rxDone: 1'b1, rxParityBad: bad, default: 1'b0}, 1);
      tick(1);
   endtask

   // Counts cycles with ready low after an access
   task automatic busy(input int e);
      n = 0;
      repeat (8) begin
         tick(1);
         if (hostAccessReady !== 1'b1) n++;
      end
      chk("readyLow", 8'(n), 8'(e));
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      host.access(1'b0, a, v, q);
      tick(2);
   endtask

   function automatic logic [7:0] ms(input logic fe, bf);
      return {cardClockInternal, fe, 1'b0, 1'b1, cardBPresent,
         cardAPresent, auxIrqPin, bf};
   endfunction

   initial begin
      seed = 22177;
      errCount = 0;
      nChecks = 0;
      peCount = 0;
      rtCount = 0;
      lcCount = 0;
      {reset, uartResetRelease, protocolT1, txMode} = 4'b1100;
      {lastCharMarker, syncMode, thresholdEnableLo} = 3'b000;
      {cardClockInternal, cardAPresent, cardBPresent, auxIrqPin} = 4'h0;
      uartEvt = '0;
      rxData = 8'h00;
      tick(3);
      reset = 1'b0;
      for (i = 0; i < 6; i++) begin
         {cardClockInternal, cardAPresent, cardBPresent, auxIrqPin} =
            4'($random(seed));
         host.access(1'b1, ADR_MIXED, 8'h00, q);
         chk("mixed", q, ms(1'b1, 1'b0));
      end
      // Both enable bits, then one alone, then random
      for (i = 0; i < 6; i++) begin
         d = i < 2 ? (i ? 8'h08 : 8'hFF) : 8'($random(seed));
         thresholdEnableLo = (i == 0) | (i > 1 & d[7]);
         wr(ADR_MIXED, d);
         chk("limit", 8'(parityRetryLimit), 8'(d[6:4]));
         chk("thresh", 8'(thresholdActive),
            8'(d[3] & thresholdEnableLo));
      end
      d = 8'($random(seed));
      wr(ADR_TIMEOUT_HIGH, d);
      chk("toHigh", timeoutCountHigh, d);
      uartResetRelease = 1'b0;
      tick(2);
      uartResetRelease = 1'b1;
      chk("toHold", timeoutCountHigh, d);
      // Depth two: third character is dropped
      wr(ADR_MIXED, 8'h01);
      rx(1'b0);
      c0 = rxData;
      rx(1'b0);
      c1 = rxData;
      rx(1'b0);
      chk("empty", 8'(rxFifoEmptyFlag), 8'h00);
      chk("full", 8'(bufferReadyFlag), 8'h01);
      host.access(1'b1, ADR_DATA_PORT, 8'h00, q);
      chk("rx0", q, c0);
      busy(3);
      chk("bufRd", 8'(bufferReadyFlag), 8'h00);
      host.access(1'b1, ADR_DATA_PORT, 8'h00, q);
      chk("rx1", q, c1);
      busy(3);
      chk("drained", 8'(rxFifoEmptyFlag), 8'h01);
      syncMode = 1'b1;
      host.access(1'b1, ADR_DATA_PORT, 8'h00, q);
      busy(0);
      syncMode = 1'b0;
      // Timeout config write: busy until the second prescaler tick
      host.access(1'b0, ADR_TIMEOUT_CFG, 8'h00, q);
      tick(4);
      chk("cfgBusy", 8'(hostAccessReady), 8'h00);
      ev('{prescTick: 1'b1, default: 1'b0}, 1);
      chk("cfgBusy1", 8'(hostAccessReady), 8'h00);
      ev('{prescTick: 1'b1, default: 1'b0}, 1);
      chk("cfgDone", 8'(hostAccessReady), 8'h01);
      txMode = 1'b1;
      tick(2);
      chk("bufTx", 8'(bufferReadyFlag), 8'h01);
      host.access(1'b0, ADR_DATA_PORT, 8'h5A, q);
      busy(3);
      chk("bufWr", 8'(bufferReadyFlag), 8'h00);
      ev('{txDone: 1'b1, default: 1'b0}, 1);
      tick(1);
      chk("bufSent", 8'(bufferReadyFlag), 8'h01);
      lastCharMarker = 1'b1;
      host.access(1'b0, ADR_DATA_PORT, 8'hA5, q);
      busy(3);
      ev('{txDone: 1'b1, default: 1'b0}, 1);
      tick(1);
      chk("bufLast", 8'(bufferReadyFlag), 8'h00);
      chk("lastDone", 8'(lcCount), 8'h01);
      {txMode, lastCharMarker} = 2'b00;
      for (i = 0; i < 2; i++) begin
         protocolT1 = i[0];
         ev('{startBit: 1'b1, default: 1'b0}, 1);
         n = i ? GUARD_ETU_T1 : GUARD_ETU_T0;
         ev('{etuTick: 1'b1, default: 1'b0}, n - 1);
         tick(1);
         chk("bgtEarly", 8'(blockGuardElapsed), 8'h00);
         ev('{etuTick: 1'b1, default: 1'b0}, 1);
         tick(1);
         chk("bgtDone", 8'(blockGuardElapsed), 8'h01);
      end
      // Limit one: a good character in between restarts the count
      wr(ADR_MIXED, 8'h11);
      protocolT1 = 1'b0;
      peCount = 0;
      rx(1'b1);
      rx(1'b0);
      rx(1'b1);
      tick(2);
      chk("peReset", 8'(peCount), 8'h00);
      rx(1'b1);
      tick(2);
      chk("peT0", 8'(peCount), 8'h01);
      protocolT1 = 1'b1;
      rx(1'b1);
      rx(1'b1);
      tick(2);
      chk("peT1", 8'(peCount), 8'h03);
      // T0 transmit, limit one: one retry at 15 ETU, then error and hold
      {protocolT1, txMode} = 2'b01;
      ev('{startBit: 1'b1, default: 1'b0}, 1);
      ev('{txNak: 1'b1, default: 1'b0}, 1);
      ev('{halfEtuTick: 1'b1, default: 1'b0}, 29);
      chk("retxEarly", 8'(rtCount), 8'h00);
      ev('{halfEtuTick: 1'b1, default: 1'b0}, 1);
      chk("retx", 8'(rtCount), 8'h01);
      chk("peRetry", 8'(peCount), 8'h03);
      ev('{startBit: 1'b1, default: 1'b0}, 1);
      ev('{txNak: 1'b1, default: 1'b0}, 1);
      chk("peTx", 8'(peCount), 8'h04);
      ev('{halfEtuTick: 1'b1, default: 1'b0}, 26);
      chk("holdOn", 8'(resendHold), 8'h01);
      ev('{halfEtuTick: 1'b1, default: 1'b0}, 1);
      chk("holdOff", 8'(resendHold), 8'h00);
      endSim();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      errCount++;
      endSim();
   end
endmodule
